// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        CLK_SYS_I   = 1'b0;
    logic        ARST_N_I    = 1'b0;
    logic        WB_CYC_I    = 1'b0;
    logic        WB_STB_I    = 1'b0;
    logic        WB_WE_I     = 1'b0;
    logic [9:0]  WB_ADR_I    = 10'h000;
    logic [3:0]  WB_SEL_I    = 4'h0;
    logic [31:0] WB_DAT_I    = 32'h0;
    logic        OP_VALID_I  = 1'b0;
    logic [2:0]  OP_CODE_I   = 3'h0;
    logic [7:0]  OP_SRC_I    = 8'h00;
    logic        PUSH_I      = 1'b0;
    logic [7:0]  PUSH_DATA_I = 8'h00;
    logic        POP_I       = 1'b0;
    logic        WB_ACK_O, STACK_WE_O, STACK_RE_O, CARRY_O;
    logic [31:0] WB_DAT_O;
    logic [15:0] PTR_WORD_O;
    logic [7:0]  STACK_ADDR_O, STACK_WDATA_O, BANK_BASE_O, ACC_O, SECOND_O;
    int          n_fail = 0;
    int          checked = 0;
    int          cycles = 0;
    localparam logic [2:0] C_ADD  = core_regs_pkg::OP_ADD;
    localparam logic [2:0] C_ADD_WITH_CARRY_OP = core_regs_pkg::OP_ADD_WITH_CARRY_OP;
    localparam logic [2:0] C_SUBTRACT_BORROW_OP = core_regs_pkg::OP_SUBTRACT_BORROW_OP;
    localparam logic [2:0] C_MUL  = core_regs_pkg::OP_MUL;
    localparam logic [2:0] C_DIV  = core_regs_pkg::OP_DIV;
    typedef struct packed {
        logic [2:0] op;
        logic [7:0] a, b, src, program_status_word, ea, eb, epsw;
    } row_t;
    // op, acc, second, src, status in, acc out, second out, status out
    row_t rows [9] = '{
        '{C_ADD,  8'h7F, 8'h11, 8'h01, 8'h00, 8'h80, 8'h11, 8'h44},
        '{C_ADD,  8'hFF, 8'h11, 8'h01, 8'h04, 8'h00, 8'h11, 8'hC0},
        '{C_ADD_WITH_CARRY_OP, 8'h0E, 8'h11, 8'h01, 8'hBA, 8'h10, 8'h11, 8'h7A},
        '{C_SUBTRACT_BORROW_OP, 8'h00, 8'h11, 8'h01, 8'h00, 8'hFF, 8'h11, 8'hC0},
        '{C_SUBTRACT_BORROW_OP, 8'h80, 8'h11, 8'h01, 8'h80, 8'h7E, 8'h11, 8'h44},
        '{C_MUL,  8'h10, 8'h10, 8'h00, 8'hC0, 8'h00, 8'h01, 8'h04},
        '{C_MUL,  8'h0F, 8'h11, 8'h00, 8'h04, 8'hFF, 8'h00, 8'h00},
        '{C_DIV,  8'h64, 8'h07, 8'h00, 8'hC4, 8'h0E, 8'h02, 8'h00},
        '{C_DIV,  8'h55, 8'h00, 8'h00, 8'h80, 8'h55, 8'h00, 8'h04}};
    logic [7:0] zero_regs [5] = '{core_regs_pkg::IDX_PTR_LOW,
        core_regs_pkg::IDX_PTR_HIGH, core_regs_pkg::IDX_STATUS,
        core_regs_pkg::IDX_MAIN_WORK, core_regs_pkg::IDX_SECOND_OP};

    core_status_pointer_regs #(.ADR_W(10)) DUT (
        .CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I),
        .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
        .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
        .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I), .OP_SRC_I(OP_SRC_I),
        .PUSH_I(PUSH_I), .PUSH_DATA_I(PUSH_DATA_I), .POP_I(POP_I),
        .STACK_WE_O(STACK_WE_O), .STACK_RE_O(STACK_RE_O),
        .STACK_ADDR_O(STACK_ADDR_O), .STACK_WDATA_O(STACK_WDATA_O),
        .PTR_WORD_O(PTR_WORD_O), .BANK_BASE_O(BANK_BASE_O),
        .ACC_O(ACC_O), .SECOND_O(SECOND_O), .CARRY_O(CARRY_O));

    always #5 CLK_SYS_I = ~CLK_SYS_I;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // holds the request until ack is sampled, no fixed latency assumed
    task automatic bus(input logic we, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge CLK_SYS_I);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_SEL_I <= 4'h1;
        WB_ADR_I <= {idx, 2'b00};
        WB_DAT_I <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge CLK_SYS_I);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 20);
        `CHK(WB_ACK_O, 1'b1)
        rd = WB_DAT_O[7:0];
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        `CHK(x, e)
    endtask

    task automatic do_reset();
        ARST_N_I <= 1'b0;
        repeat (10) @(posedge CLK_SYS_I);
        ARST_N_I <= 1'b1;
        repeat (3) @(posedge CLK_SYS_I);
    endtask

    task automatic check_reset();
        `CHK({PTR_WORD_O, BANK_BASE_O, ACC_O, SECOND_O, CARRY_O}, 41'h0)
        chk_rd(core_regs_pkg::IDX_STACK_TOP, core_regs_pkg::STACK_TOP_RESET);
        foreach (zero_regs[i]) chk_rd(zero_regs[i], 8'h00);
    endtask

    task automatic do_op(input logic [2:0] code, input logic [7:0] src);
        @(posedge CLK_SYS_I);
        OP_VALID_I <= 1'b1;
        OP_CODE_I  <= code;
        OP_SRC_I   <= src;
        @(posedge CLK_SYS_I);
        OP_VALID_I <= 1'b0;
    endtask

    always @(posedge CLK_SYS_I) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        check_reset();
        foreach (rows[i]) begin
            wr(core_regs_pkg::IDX_MAIN_WORK, rows[i].a);
            wr(core_regs_pkg::IDX_SECOND_OP, rows[i].b);
            wr(core_regs_pkg::IDX_STATUS, rows[i].program_status_word);
            do_op(rows[i].op, rows[i].src);
            #1;
            `CHK({ACC_O, SECOND_O}, {rows[i].ea, rows[i].eb})
            `CHK(CARRY_O, rows[i].epsw[7])
            chk_rd(core_regs_pkg::IDX_STATUS,
                   {rows[i].epsw[7:1], ^rows[i].ea});
        end
        // bank change, parity bit write dropped; no reserved bits set
        wr(core_regs_pkg::IDX_MAIN_WORK, 8'h03);
        for (int k = 0; k < 4; k++) begin
            wr(core_regs_pkg::IDX_STATUS, {3'b000, 2'(k), 3'b001});
            #1;
            `CHK(BANK_BASE_O, {3'b000, 2'(k), 3'b000})
            chk_rd(core_regs_pkg::IDX_STATUS, {3'b000, 2'(k), 3'b000});
        end
        wr(core_regs_pkg::IDX_PTR_LOW, 8'h34);
        wr(core_regs_pkg::IDX_PTR_HIGH, 8'h12);
        #1;
        `CHK(PTR_WORD_O, 16'h1234)
        wr(8'h84, 8'h5A);
        chk_rd(8'h84, 8'h00);
        // back-to-back pushes across the wrap, then pops
        wr(core_regs_pkg::IDX_STACK_TOP, 8'hFE);
        @(posedge CLK_SYS_I);
        PUSH_I      <= 1'b1;
        PUSH_DATA_I <= 8'hA5;
        @(posedge CLK_SYS_I);
        PUSH_DATA_I <= 8'h5A;
        #1;
        `CHK({STACK_WE_O, STACK_ADDR_O, STACK_WDATA_O}, 17'h1FFA5)
        @(posedge CLK_SYS_I);
        PUSH_I <= 1'b0;
        POP_I  <= 1'b1;
        #1;
        `CHK({STACK_WE_O, STACK_ADDR_O, STACK_WDATA_O}, 17'h1005A)
        @(posedge CLK_SYS_I);
        #1;
        `CHK({STACK_RE_O, STACK_WE_O, STACK_ADDR_O}, 10'h200)
        @(posedge CLK_SYS_I);
        POP_I <= 1'b0;
        #1;
        `CHK({STACK_RE_O, STACK_ADDR_O}, 9'h1FF)
        chk_rd(core_regs_pkg::IDX_STACK_TOP, 8'hFE);
        // second reset in mid-run after all registers were touched
        do_reset();
        check_reset();
        complete_run();
    end
endmodule

// ---- verilog/arith_flags.sv ----
`timescale 1ns/1ps
module arith_flags (
    // operation
    input  wire logic [2:0] op_i,
    input  wire logic [7:0] acc_i,
    input  wire logic [7:0] src_i,
    input  wire logic [7:0] second_i,
    input  wire logic       carry_i,
    // results
    output logic      [7:0] res_acc_o,
    output logic      [7:0] res_second_o,
    output logic            res_second_we_o,
    output logic            carry_o,
    output logic            half_o,
    output logic            ov_o
);

    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic        cin;
    logic [15:0] prod;
    logic        sub;

    assign sub  = (op_i == core_regs_pkg::OP_SUBTRACT_BORROW_OP);
    assign cin  = (op_i == core_regs_pkg::OP_ADD) ? 1'b0 : carry_i;
    assign prod = acc_i * second_i;

    always_comb begin
        sum9            = 9'h000;
        nib5            = 5'h00;
        res_acc_o       = acc_i;
        res_second_o    = second_i;
        res_second_we_o = 1'b0;
        carry_o         = 1'b0;
        half_o          = 1'b0;
        ov_o            = 1'b0;
        case (op_i)
            core_regs_pkg::OP_ADD, core_regs_pkg::OP_ADD_WITH_CARRY_OP,
            core_regs_pkg::OP_SUBTRACT_BORROW_OP: begin
                if (sub) begin
                    sum9 = {1'b0, acc_i} - {1'b0, src_i} - {8'h00, cin};
                    nib5 = {1'b0, acc_i[3:0]} - {1'b0, src_i[3:0]}
                         - {4'h0, cin};
                    // borrow is the sign of the widened difference
                    ov_o = (acc_i[7] ^ src_i[7]) & (acc_i[7] ^ sum9[7]);
                end else begin
                    sum9 = {1'b0, acc_i} + {1'b0, src_i} + {8'h00, cin};
                    nib5 = {1'b0, acc_i[3:0]} + {1'b0, src_i[3:0]}
                         + {4'h0, cin};
                    ov_o = ~(acc_i[7] ^ src_i[7]) & (acc_i[7] ^ sum9[7]);
                end
                res_acc_o = sum9[7:0];
                carry_o   = sum9[8];
                half_o    = nib5[4];
            end
            core_regs_pkg::OP_MUL: begin
                res_acc_o       = prod[7:0];
                res_second_o    = prod[15:8];
                res_second_we_o = 1'b1;
                ov_o            = (prod[15:8] != 8'h00);
            end
            core_regs_pkg::OP_DIV: begin
                res_second_we_o = 1'b1;
                if (second_i == 8'h00) begin
                    // quotient and remainder left as they were
                    ov_o = 1'b1;
                end else begin
                    res_acc_o    = acc_i / second_i;
                    res_second_o = acc_i % second_i;
                end
            end
            default: begin
                res_acc_o = acc_i;
            end
        endcase
    end

endmodule

// ---- verilog/core_regs_pkg.sv ----
package core_regs_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_STACK_TOP   = 8'h81;
    localparam logic [7:0] IDX_PTR_LOW     = 8'h82;
    localparam logic [7:0] IDX_PTR_HIGH    = 8'h83;
    localparam logic [7:0] IDX_STATUS      = 8'hD0;
    localparam logic [7:0] IDX_MAIN_WORK   = 8'hE0;
    localparam logic [7:0] IDX_SECOND_OP   = 8'hF0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STACK_TOP_RESET = 8'h07;
    localparam logic [7:0] CORE_REG_RESET  = 8'h00;

    // ------------------------------------------------------------
    // status word field positions
    // ------------------------------------------------------------
    localparam int CARRY_BIT      = 7;
    localparam int HALF_CARRY_BIT = 6;
    localparam int USER_ZERO_BIT  = 5;
    localparam int BANK_HIGH_BIT  = 4;
    localparam int BANK_LOW_BIT   = 3;
    localparam int SIGNED_OV_BIT  = 2;
    localparam int USER_ONE_BIT   = 1;
    localparam int PARITY_BIT     = 0;

    // ------------------------------------------------------------
    // arithmetic operation codes
    // ------------------------------------------------------------
    localparam logic [2:0] OP_ADD  = 3'h0;
    localparam logic [2:0] OP_ADD_WITH_CARRY_OP = 3'h1;
    localparam logic [2:0] OP_SUBTRACT_BORROW_OP = 3'h2;
    localparam logic [2:0] OP_MUL  = 3'h3;
    localparam logic [2:0] OP_DIV  = 3'h4;

    // ------------------------------------------------------------
    // bus
    // ------------------------------------------------------------
    localparam int WB_ADR_MIN = 10;

endpackage

// ---- verilog/core_status_pointer_regs.sv ----
// Contract
// - reset puts the stack pointer at 0x07 and every other register at 0.
// - a push first increments the stack pointer, then writes there.
// - the pointer word is high byte in 15..8 and low byte in 7..0.
// - the pointer word addresses indirect data and program accesses.
// - carry is set on add carry-out or subtract borrow, else cleared.
// - half carry is set on nibble carry or borrow, else cleared.
// - status bits 4-3 pick working bank base 0x00, 0x08, 0x10, 0x18.
// - overflow is set on signed overflow of add, add-carry, subtract.
// - overflow is set when a product exceeds 255.
// - overflow is set on division by zero.
// - those five operations clear overflow when it does not occur.
// - status bit 0 is read-only odd parity of the accumulator.
// - status bits 5 and 1 change only on software writes.
// - a second register gives the extra operand and extra result.
`timescale 1ns/1ps
module core_status_pointer_regs #(
    parameter int ADR_W = 10
) (
    // clock and reset
    input  wire logic             CLK_SYS_I,
    input  wire logic             ARST_N_I,
    // wishbone slave
    input  wire logic             WB_CYC_I,
    input  wire logic             WB_STB_I,
    input  wire logic             WB_WE_I,
    input  wire logic [ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]       WB_SEL_I,
    input  wire logic [31:0]      WB_DAT_I,
    output logic                  WB_ACK_O,
    output logic      [31:0]      WB_DAT_O,
    // execution unit
    input  wire logic             OP_VALID_I,
    input  wire logic [2:0]       OP_CODE_I,
    input  wire logic [7:0]       OP_SRC_I,
    input  wire logic             PUSH_I,
    input  wire logic [7:0]       PUSH_DATA_I,
    input  wire logic             POP_I,
    // stack memory strobes
    output logic                  STACK_WE_O,
    output logic                  STACK_RE_O,
    output logic      [7:0]       STACK_ADDR_O,
    output logic      [7:0]       STACK_WDATA_O,
    // core state
    output logic      [15:0]      PTR_WORD_O,
    output logic      [7:0]       BANK_BASE_O,
    output logic      [7:0]       ACC_O,
    output logic      [7:0]       SECOND_O,
    output logic                  CARRY_O
);

    // index is taken from address bits 9..2, so narrower buses cannot work
    if (ADR_W < core_regs_pkg::WB_ADR_MIN) begin : g_adr_check
        $error("ADR_W too small for the register index");
    end

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // bus slave and decode
    // ------------------------------------------------------------
    logic [7:0] idx;
    logic       wr;
    logic [7:0] rd_data;
    logic [7:0] wdat;
    logic       wr_sp;
    logic       wr_dpl;
    logic       wr_dph;
    logic       wr_psw;
    logic       wr_acc;
    logic       wr_b;

    logic [7:0] sp_q;
    logic [7:0] dpl_q;
    logic [7:0] dph_q;
    logic [7:1] psw_q;
    logic [7:0] acc_q;
    logic [7:0] b_q;
    logic [7:0] psw_rd;
    logic       parity;

    wb_byte_slave #(
        .ADR_W (ADR_W)
    ) u_slave (
        .clk_i     (CLK_SYS_I),
        .rst_n_i   (rst_n),
        .cyc_i     (WB_CYC_I),
        .stb_i     (WB_STB_I),
        .we_i      (WB_WE_I),
        .adr_i     (WB_ADR_I),
        .sel_i     (WB_SEL_I),
        .wdat_i    (WB_DAT_I[7:0]),
        .ack_o     (WB_ACK_O),
        .rdat_o    (WB_DAT_O),
        .idx_o     (idx),
        .wr_o      (wr),
        .rd_data_i (rd_data)
    );

    assign wdat   = WB_DAT_I[7:0];
    assign wr_sp  = wr & (idx == core_regs_pkg::IDX_STACK_TOP);
    assign wr_dpl = wr & (idx == core_regs_pkg::IDX_PTR_LOW);
    assign wr_dph = wr & (idx == core_regs_pkg::IDX_PTR_HIGH);
    assign wr_psw = wr & (idx == core_regs_pkg::IDX_STATUS);
    assign wr_acc = wr & (idx == core_regs_pkg::IDX_MAIN_WORK);
    assign wr_b   = wr & (idx == core_regs_pkg::IDX_SECOND_OP);

    // parity is never stored, so it cannot lag the accumulator
    assign parity = ^acc_q;
    assign psw_rd = {psw_q, parity};

    // unmapped indices read as zero
    assign rd_data =
        (idx == core_regs_pkg::IDX_STACK_TOP) ? sp_q  :
        (idx == core_regs_pkg::IDX_PTR_LOW)   ? dpl_q :
        (idx == core_regs_pkg::IDX_PTR_HIGH)  ? dph_q :
        (idx == core_regs_pkg::IDX_STATUS)    ? psw_rd :
        (idx == core_regs_pkg::IDX_MAIN_WORK) ? acc_q :
        (idx == core_regs_pkg::IDX_SECOND_OP) ? b_q   : 8'h00;

    // ------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------
    logic [7:0] res_acc;
    logic [7:0] res_b;
    logic       res_b_we;
    logic       f_cy;
    logic       f_ac;
    logic       f_ov;
    logic       is_muldiv;

    assign is_muldiv = (OP_CODE_I == core_regs_pkg::OP_MUL) |
                       (OP_CODE_I == core_regs_pkg::OP_DIV);

    arith_flags u_arith (
        .op_i            (OP_CODE_I),
        .acc_i           (acc_q),
        .src_i           (OP_SRC_I),
        .second_i        (b_q),
        .carry_i         (psw_q[core_regs_pkg::CARRY_BIT]),
        .res_acc_o       (res_acc),
        .res_second_o    (res_b),
        .res_second_we_o (res_b_we),
        .carry_o         (f_cy),
        .half_o          (f_ac),
        .ov_o            (f_ov)
    );

    // ------------------------------------------------------------
    // stack and pointer registers
    // ------------------------------------------------------------
    logic       push_ok;
    logic       pop_ok;
    logic [7:0] sp_inc;
    logic [7:0] sp_dec;

    // software write to the pointer wins over a same-cycle push or pop
    assign push_ok = PUSH_I & ~wr_sp;
    assign pop_ok  = POP_I & ~PUSH_I & ~wr_sp;
    assign sp_inc  = sp_q + 8'h01;
    assign sp_dec  = sp_q - 8'h01;

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            sp_q          <= core_regs_pkg::STACK_TOP_RESET;
            dpl_q         <= core_regs_pkg::CORE_REG_RESET;
            dph_q         <= core_regs_pkg::CORE_REG_RESET;
            STACK_WE_O    <= 1'b0;
            STACK_RE_O    <= 1'b0;
            STACK_ADDR_O  <= 8'h00;
            STACK_WDATA_O <= 8'h00;
        end else begin
            STACK_WE_O <= push_ok;
            STACK_RE_O <= pop_ok;
            if (wr_sp) begin
                sp_q <= wdat;
            end else if (push_ok) begin
                sp_q          <= sp_inc;
                STACK_ADDR_O  <= sp_inc;
                STACK_WDATA_O <= PUSH_DATA_I;
            end else if (pop_ok) begin
                STACK_ADDR_O <= sp_q;
                sp_q         <= sp_dec;
            end
            if (wr_dpl) begin
                dpl_q <= wdat;
            end
            if (wr_dph) begin
                dph_q <= wdat;
            end
        end
    end

    assign PTR_WORD_O = {dph_q, dpl_q};

    // ------------------------------------------------------------
    // accumulators and status word
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= core_regs_pkg::CORE_REG_RESET;
            b_q   <= core_regs_pkg::CORE_REG_RESET;
            psw_q <= 7'h00;
        end else begin
            if (wr_acc) begin
                acc_q <= wdat;
            end else if (OP_VALID_I) begin
                acc_q <= res_acc;
            end
            if (wr_b) begin
                b_q <= wdat;
            end else if (OP_VALID_I && res_b_we) begin
                b_q <= res_b;
            end
            if (wr_psw) begin
                // bit 0 is dropped: parity is read-only
                psw_q <= wdat[7:1];
            end else if (OP_VALID_I) begin
                psw_q[core_regs_pkg::CARRY_BIT]      <= f_cy & ~is_muldiv;
                psw_q[core_regs_pkg::HALF_CARRY_BIT] <= f_ac & ~is_muldiv;
                psw_q[core_regs_pkg::SIGNED_OV_BIT]  <= f_ov;
            end
        end
    end

    // bank base straight from the select bits; mind the one-op hazard
    assign BANK_BASE_O = {3'h0, psw_q[core_regs_pkg::BANK_HIGH_BIT],
                          psw_q[core_regs_pkg::BANK_LOW_BIT], 3'h0};
    assign ACC_O       = acc_q;
    assign SECOND_O    = b_q;
    assign CARRY_O     = psw_q[core_regs_pkg::CARRY_BIT];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic op_free;
    logic rd_psw;

    assign op_free = OP_VALID_I & ~wr_acc & ~wr_b & ~wr_psw;
    assign rd_psw  = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~WB_ACK_O &
                     (idx == core_regs_pkg::IDX_STATUS);

    property p_reset_vals;
        @(posedge CLK_SYS_I) $rose(rst_n) |->
            sp_q == 8'h07 && acc_q == 8'h00 && PTR_WORD_O == 16'h0000;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_push;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        push_ok |=> STACK_WE_O && sp_q == $past(sp_q) + 8'h01 &&
                    STACK_ADDR_O == sp_q;
    endproperty
    a_push: assert property (p_push)
        else $error("push did not pre-increment");

    property p_pop;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        pop_ok |=> STACK_RE_O && STACK_ADDR_O == $past(sp_q) &&
                   sp_q == $past(sp_q) - 8'h01;
    endproperty
    a_pop: assert property (p_pop)
        else $error("pop order wrong");

    property p_ptr;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_dph |=> PTR_WORD_O[15:8] == $past(WB_DAT_I[7:0]);
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("high byte not in upper pointer half");

    property p_carry;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        op_free && OP_CODE_I == core_regs_pkg::OP_ADD |=>
            CARRY_O == (({1'b0, $past(acc_q)} + {1'b0, $past(OP_SRC_I)})
                        > 9'h0FF);
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry wrong after add");

    property p_half;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        op_free && OP_CODE_I == core_regs_pkg::OP_ADD |=>
            psw_q[6] == (({1'b0, $past(acc_q[3:0])} +
                          {1'b0, $past(OP_SRC_I[3:0])}) > 5'h0F);
    endproperty
    a_half: assert property (p_half)
        else $error("half carry wrong after add");

    property p_bank;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_psw |=> BANK_BASE_O == {3'h0, $past(WB_DAT_I[4:3]), 3'h0};
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank base wrong");

    property p_mul_ov;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        op_free && OP_CODE_I == core_regs_pkg::OP_MUL |=>
            psw_q[2] == (($past(acc_q) * $past(b_q)) > 16'd255);
    endproperty
    a_mul_ov: assert property (p_mul_ov)
        else $error("product overflow flag wrong");

    property p_div_ov;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        op_free && OP_CODE_I == core_regs_pkg::OP_DIV |=>
            psw_q[2] == ($past(b_q) == 8'h00);
    endproperty
    a_div_ov: assert property (p_div_ov)
        else $error("divide overflow flag wrong");

    property p_parity;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        rd_psw |=> WB_ACK_O && WB_DAT_O[0] == ^$past(acc_q);
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity readback wrong");

    property p_user;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        !wr_psw |=> psw_q[5] == $past(psw_q[5]) &&
                    psw_q[1] == $past(psw_q[1]);
    endproperty
    a_user: assert property (p_user)
        else $error("user flag changed by hardware");

    c_push:    cover property (@(posedge CLK_SYS_I) push_ok);
    c_pop:     cover property (@(posedge CLK_SYS_I) pop_ok);
    c_mul_big: cover property (@(posedge CLK_SYS_I)
        op_free && OP_CODE_I == core_regs_pkg::OP_MUL && res_b != 8'h00);
    c_bank3:   cover property (@(posedge CLK_SYS_I)
        BANK_BASE_O == 8'h18);

endmodule

// ---- verilog/wb_byte_slave.sv ----
`timescale 1ns/1ps
module wb_byte_slave #(
    parameter int ADR_W = 10
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // wishbone
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [7:0]       wdat_i,
    output logic                  ack_o,
    output logic      [31:0]      rdat_o,
    // register side
    output logic      [7:0]       idx_o,
    output logic                  wr_o,
    input  wire logic [7:0]       rd_data_i
);

    logic        ack_q;
    logic [31:0] rdat_q;
    logic        req;

    // one-cycle answer; ack drops after one cycle so no double write
    assign req    = cyc_i & stb_i & ~ack_q;
    assign idx_o  = adr_i[9:2];
    assign wr_o   = req & we_i & sel_i[0];
    assign ack_o  = ack_q;
    assign rdat_o = rdat_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !we_i) begin
                rdat_q <= {24'h000000, rd_data_i};
            end
        end
    end

endmodule
